// *** tb/gmc_regs_tb.sv ***
// Self-checking testbench for the graphics memory control register
`timescale 1ns/1ps
`default_nettype none
module gmc_regs_tb;
   import gmc_pkg::*;
   typedef struct packed {
      logic [7:0]  addr;
      logic [1:0]  be;
      logic [15:0] data;
      logic        lock;
      logic [15:0] exp;
   } gmc_step_s;
   logic        clk, arst_n, clk_en, cfg_wr, smm_space_lock;
   logic [7:0]  cfg_addr, gfx_subclass;
   logic [1:0]  cfg_be;
   logic [15:0] cfg_wdata, cfg_rdata;
   logic [9:0]  xlat_table_mb, frame_buffer_mb;
   logic        xlat_cycles_claim, vga_cycles_claim;
   int          miscompares, comparisons;
   logic [9:0]  fb_tab [16] = '{10'h000, 10'h001, 10'h004, 10'h008, 10'h010, 10'h020, 10'h030,
                                10'h040, 10'h080, 10'h100, 10'h000, 10'h000, 10'h000, 10'h000,
                                10'h000, 10'h000};
   // Lock, byte enables and offset vary; the disable bit stays set while the buffer
   // code is zero
   gmc_step_s   steps [7] = '{{8'h52, 2'h3, 16'h0102, 1'b0, 16'h0102},
                              {8'h52, 2'h3, 16'hFFFF, 1'b0, 16'h03F2},
                              {8'h52, 2'h1, 16'h0030, 1'b0, 16'h0330},
                              {8'h52, 2'h2, 16'h01F2, 1'b0, 16'h0130},
                              {8'h50, 2'h3, 16'h0000, 1'b0, 16'h0130},
                              {8'h52, 2'h3, 16'h0002, 1'b1, 16'h0132},
                              {8'h52, 2'h3, 16'h0002, 1'b0, 16'h0002}};
   gmc_regs DUT (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .cfg_wr(cfg_wr),
                 .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
                 .smm_space_lock(smm_space_lock), .cfg_rdata(cfg_rdata),
                 .xlat_table_mb(xlat_table_mb), .frame_buffer_mb(frame_buffer_mb),
                 .xlat_cycles_claim(xlat_cycles_claim), .vga_cycles_claim(vga_cycles_claim),
                 .gfx_subclass(gfx_subclass));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Reads are combinational and not address-qualified, so the word stands once settled
   task automatic rd(output logic [15:0] d);
      d = cfg_rdata;
   endtask : rd
   // Decoded outputs are worked out from the expected register word
   task automatic ck(input logic [15:0] e);
      logic        claim;
      logic [15:0] word;
      claim = !e[1] && e[7:4] != 4'h0;
      rd(word);
      chk("rdata", word, e);
      chk("xlat_mb", 16'(xlat_table_mb), 16'(e[9:8] == 2'h1));
      chk("xlat_claim", 16'(xlat_cycles_claim), 16'(e[9:8] == 2'h1));
      chk("fb_mb", 16'(frame_buffer_mb), 16'(fb_tab[e[7:4]]));
      chk("vga_claim", 16'(vga_cycles_claim), 16'(claim));
      chk("subclass", 16'(gfx_subclass), claim ? 16'h0000 : 16'h0080);
   endtask : ck
   // Write strobe lasts one cycle, then one idle cycle so strobes never abut
   task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
      cfg_addr  = a;
      cfg_be    = be;
      cfg_wdata = d;
      cfg_wr    = 1'b1;
      @(negedge clk);
      cfg_wr    = 1'b0;
      @(negedge clk);
   endtask : wr
   initial begin
      #(8 * 400);
      miscompares++;
      results();
   end
   initial begin
      {arst_n, clk_en, cfg_wr, smm_space_lock} = 4'h4;
      {cfg_addr, cfg_be, cfg_wdata} = 26'h0;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      ck(GMC_RESET);
      foreach (steps[i]) begin
         smm_space_lock = steps[i].lock;
         wr(steps[i].addr, steps[i].be, steps[i].data);
         ck(steps[i].exp);
      end
      smm_space_lock = 1'b0;
      for (int c = 1; c <= 9; c++) begin
         wr(8'h52, 2'h3, {8'h01, 4'(c), 4'h0});
         ck({8'h01, 4'(c), 4'h0});
      end
      clk_en = 1'b0;
      wr(8'h52, 2'h3, 16'h0002);
      ck(16'h0190);
      clk_en = 1'b1;
      arst_n = 1'b0;
      @(negedge clk);
      ck(GMC_RESET);
      arst_n = 1'b1;
      @(negedge clk);
      results();
   end
endmodule : gmc_regs_tb
`default_nettype wire

// *** verilog/gmc_decode.sv ***
// Decodes stored allocation fields into sizes and claim controls
`timescale 1ns/1ps
`default_nettype none
module gmc_decode
   import gmc_pkg::*;
(
   gmc_decode_if.dec d
);
   always_comb begin
      // Reserved codes 10 and 11 reserve nothing and claim nothing
      d.xlat_mb    = (d.xlat_size == GMC_XLAT_1MB) ? GMC_XLAT_MB_1 : 10'h000;
      d.xlat_claim = (d.xlat_size == GMC_XLAT_1MB);
      d.fb_mb      = gmc_fb_mb(d.fb_size);
      // Either no frame buffer or the disable bit drops VGA decoding
      d.vga_claim  = !d.vga_dis && (d.fb_size != GMC_FB_NONE);
      d.subclass   = d.vga_claim ? GMC_SUBCLASS_VGA : GMC_SUBCLASS_OTHER;
   end
endmodule : gmc_decode
`default_nettype wire

// *** verilog/gmc_decode_if.sv ***
// Interface carrying the stored fields to the decode module
`timescale 1ns/1ps
`default_nettype none
interface gmc_decode_if;
   logic [1:0] xlat_size;
   logic [3:0] fb_size;
   logic       vga_dis;
   logic [9:0] xlat_mb;
   logic [9:0] fb_mb;
   logic       xlat_claim;
   logic       vga_claim;
   logic [7:0] subclass;
   modport regs (output xlat_size, fb_size, vga_dis,
                 input xlat_mb, fb_mb, xlat_claim, vga_claim, subclass);
   modport dec  (input xlat_size, fb_size, vga_dis,
                 output xlat_mb, fb_mb, xlat_claim, vga_claim, subclass);
endinterface : gmc_decode_if
`default_nettype wire

// *** verilog/gmc_pkg.sv ***
// Package for the graphics memory control register block
package gmc_pkg;
   localparam logic [7:0]  GMC_CFG_OFFSET     = 8'h52;
   localparam int          GMC_WIDTH          = 16;
   localparam logic [15:0] GMC_RESET          = 16'h0030;
   localparam int          GMC_XLAT_HI        = 9;
   localparam int          GMC_XLAT_LO        = 8;
   localparam int          GMC_FB_HI          = 7;
   localparam int          GMC_FB_LO          = 4;
   localparam int          GMC_VGA_DIS_BIT    = 1;
   localparam logic [1:0]  GMC_XLAT_RESET     = 2'h0;
   localparam logic [3:0]  GMC_FB_RESET       = 4'h3;
   localparam logic        GMC_VGA_DIS_RESET  = 1'b0;
   localparam logic [1:0]  GMC_XLAT_NONE      = 2'h0;
   localparam logic [1:0]  GMC_XLAT_1MB       = 2'h1;
   localparam logic [3:0]  GMC_FB_NONE        = 4'h0;
   localparam logic [3:0]  GMC_FB_MAX_CODE    = 4'h9;
   localparam logic [7:0]  GMC_SUBCLASS_VGA   = 8'h00;
   localparam logic [7:0]  GMC_SUBCLASS_OTHER = 8'h80;
   localparam logic [9:0]  GMC_XLAT_MB_1      = 10'h001;
   // Frame-buffer sizes in megabytes, indexed by code
   function automatic logic [9:0] gmc_fb_mb(input logic [3:0] code);
      logic [9:0] mb;
      mb = 10'h000;
      unique case (code)
         4'h1:    mb = 10'h001;
         4'h2:    mb = 10'h004;
         4'h3:    mb = 10'h008;
         4'h4:    mb = 10'h010;
         4'h5:    mb = 10'h020;
         4'h6:    mb = 10'h030;
         4'h7:    mb = 10'h040;
         4'h8:    mb = 10'h080;
         4'h9:    mb = 10'h100;
         default: mb = 10'h000;
      endcase
      return mb;
   endfunction : gmc_fb_mb
endpackage : gmc_pkg

// *** verilog/gmc_regs.sv ***
// Graphics memory control configuration register at offset 52h
`timescale 1ns/1ps
`default_nettype none
module gmc_regs
   import gmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire logic        cfg_wr,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [1:0]  cfg_be,
   input  wire logic [15:0] cfg_wdata,
   input  wire logic        smm_space_lock,
   output logic      [15:0] cfg_rdata,
   output logic      [9:0]  xlat_table_mb,
   output logic      [9:0]  frame_buffer_mb,
   output logic             xlat_cycles_claim,
   output logic             vga_cycles_claim,
   output logic      [7:0]  gfx_subclass
);
   logic [1:0] xlat_size_q, xlat_size_d;
   logic [3:0] fb_size_q,   fb_size_d;
   logic       vga_dis_q,   vga_dis_d;
   logic       hit;

   gmc_decode_if dif ();

   // Byte-lane write decode shared by all three stored fields
   function automatic logic lane_wr(input logic wr_hit, input logic lane_en, input logic locked);
      return wr_hit && lane_en && !locked;
   endfunction : lane_wr

   // Word-wide access: the register occupies bytes 52h and 53h
   assign hit = cfg_wr && (cfg_addr == GMC_CFG_OFFSET);

   always_comb begin
      xlat_size_d = xlat_size_q;
      fb_size_d   = fb_size_q;
      vga_dis_d   = vga_dis_q;
      if (lane_wr(hit, cfg_be[1], smm_space_lock)) begin
         xlat_size_d = cfg_wdata[GMC_XLAT_HI:GMC_XLAT_LO];
      end
      if (lane_wr(hit, cfg_be[0], smm_space_lock)) begin
         fb_size_d = cfg_wdata[GMC_FB_HI:GMC_FB_LO];
      end
      // Disable bit is not covered by the lock
      if (lane_wr(hit, cfg_be[0], 1'b0)) begin
         vga_dis_d = cfg_wdata[GMC_VGA_DIS_BIT];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xlat_size_q <= GMC_XLAT_RESET;
         fb_size_q   <= GMC_FB_RESET;
         vga_dis_q   <= GMC_VGA_DIS_RESET;
      end else if (clk_en) begin
         xlat_size_q <= xlat_size_d;
         fb_size_q   <= fb_size_d;
         vga_dis_q   <= vga_dis_d;
      end
   end

   always_comb begin
      cfg_rdata = 16'h0000;
      cfg_rdata[GMC_XLAT_HI:GMC_XLAT_LO] = xlat_size_q;
      cfg_rdata[GMC_FB_HI:GMC_FB_LO]     = fb_size_q;
      cfg_rdata[GMC_VGA_DIS_BIT]         = vga_dis_q;
   end

   assign dif.xlat_size = xlat_size_q;
   assign dif.fb_size   = fb_size_q;
   assign dif.vga_dis   = vga_dis_q;

   gmc_decode u_dec (
      .d (dif.dec)
   );

   assign xlat_table_mb     = dif.xlat_mb;
   assign frame_buffer_mb   = dif.fb_mb;
   assign xlat_cycles_claim = dif.xlat_claim;
   assign vga_cycles_claim  = dif.vga_claim;
   assign gfx_subclass      = dif.subclass;

   chk_lock_holds_xlat: assert property (@(posedge clk) disable iff (!arst_n)
      smm_space_lock |=> $stable(xlat_size_q) || !$past(smm_space_lock))
      else $error("table size changed while locked");
   chk_lock_holds_fb: assert property (@(posedge clk) disable iff (!arst_n)
      (smm_space_lock && $past(smm_space_lock)) |-> $stable(fb_size_q))
      else $error("frame buffer size changed while locked");
   chk_write_updates_fb: assert property (@(posedge clk) disable iff (!arst_n)
      (hit && clk_en && !smm_space_lock && cfg_be[0])
      |=> fb_size_q == $past(cfg_wdata[GMC_FB_HI:GMC_FB_LO]))
      else $error("frame buffer write lost");
   chk_xlat_none: assert property (@(posedge clk) disable iff (!arst_n)
      xlat_size_q == GMC_XLAT_NONE |-> !xlat_cycles_claim && xlat_table_mb == 10'h000)
      else $error("table claimed with no allocation");
   chk_xlat_one_mb: assert property (@(posedge clk) disable iff (!arst_n)
      xlat_size_q == GMC_XLAT_1MB |-> xlat_table_mb == GMC_XLAT_MB_1 && xlat_cycles_claim)
      else $error("table size not 1 MB");
   chk_fb_none_sub: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == GMC_FB_NONE |-> !vga_cycles_claim && gfx_subclass == GMC_SUBCLASS_OTHER)
      else $error("VGA claimed without frame buffer");
   chk_vga_enabled: assert property (@(posedge clk) disable iff (!arst_n)
      (!vga_dis_q && fb_size_q != GMC_FB_NONE) |-> vga_cycles_claim
      && gfx_subclass == GMC_SUBCLASS_VGA)
      else $error("VGA not claimed while enabled");
   chk_vga_disabled: assert property (@(posedge clk) disable iff (!arst_n)
      vga_dis_q |-> !vga_cycles_claim && gfx_subclass == GMC_SUBCLASS_OTHER)
      else $error("VGA claimed while disabled");
   chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
      cfg_rdata[15:10] == 6'h00 && cfg_rdata[3:2] == 2'h0 && !cfg_rdata[0])
      else $error("reserved bit reads one");
   chk_fb_max_size: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == GMC_FB_MAX_CODE |-> frame_buffer_mb == 10'h100)
      else $error("largest frame buffer wrong");

   // Write paths and hold paths, lane by lane
   chk_write_updates_xlat: assert property (@(posedge clk) disable iff (!arst_n)
      (hit && clk_en && !smm_space_lock && cfg_be[1])
      |=> xlat_size_q == $past(cfg_wdata[GMC_XLAT_HI:GMC_XLAT_LO]))
      else $error("table size write lost");

   chk_write_updates_vga: assert property (@(posedge clk) disable iff (!arst_n)
      (hit && clk_en && cfg_be[0])
      |=> vga_dis_q == $past(cfg_wdata[GMC_VGA_DIS_BIT]))
      else $error("disable bit write lost");

   chk_lane_hold_xlat: assert property (@(posedge clk) disable iff (!arst_n)
      (hit && !cfg_be[1]) |=> $stable(xlat_size_q))
      else $error("table size changed without its byte enable");

   chk_lane_hold_low: assert property (@(posedge clk) disable iff (!arst_n)
      (hit && !cfg_be[0]) |=> $stable(fb_size_q) && $stable(vga_dis_q))
      else $error("low byte changed without its byte enable");

   chk_lock_refuses: assert property (@(posedge clk) disable iff (!arst_n)
      (hit && smm_space_lock) |=> $stable(xlat_size_q) && $stable(fb_size_q))
      else $error("size field written while locked");

   chk_other_addr: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg_wr && cfg_addr != GMC_CFG_OFFSET)
      |=> $stable(xlat_size_q) && $stable(fb_size_q) && $stable(vga_dis_q))
      else $error("write to another offset changed the register");

   chk_enable_freezes: assert property (@(posedge clk) disable iff (!arst_n)
      !clk_en |=> $stable(xlat_size_q) && $stable(fb_size_q) && $stable(vga_dis_q))
      else $error("state moved while clock enable low");

   // Reset values, seen at the first edge after release, before any write can land
   chk_reset_word: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(arst_n) |-> cfg_rdata == GMC_RESET)
      else $error("register word wrong after reset");

   chk_reset_decode: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(arst_n) |-> !xlat_cycles_claim && frame_buffer_mb == 10'h008
      && vga_cycles_claim && gfx_subclass == GMC_SUBCLASS_VGA)
      else $error("decoded outputs wrong after reset");

   // Decoded outputs against the stored codes
   chk_xlat_reserved: assert property (@(posedge clk) disable iff (!arst_n)
      xlat_size_q[1] |-> !xlat_cycles_claim && xlat_table_mb == 10'h000)
      else $error("reserved table code claimed memory");

   chk_xlat_claim_code: assert property (@(posedge clk) disable iff (!arst_n)
      xlat_cycles_claim |-> xlat_size_q == GMC_XLAT_1MB)
      else $error("table claimed by a code other than 01");

   chk_fb_none_mb: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == GMC_FB_NONE |-> frame_buffer_mb == 10'h000)
      else $error("memory reserved for buffer code zero");

   chk_fb_one_mb: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == 4'h1 |-> frame_buffer_mb == 10'h001)
      else $error("smallest frame buffer wrong");

   chk_fb_reset_mb: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == GMC_FB_RESET |-> frame_buffer_mb == 10'h008)
      else $error("default frame buffer wrong");

   chk_fb_odd_size: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == 4'h6 |-> frame_buffer_mb == 10'h030)
      else $error("48 MB frame buffer wrong");

   chk_fb_above_max: assert property (@(posedge clk) disable iff (!arst_n)
      fb_size_q > GMC_FB_MAX_CODE |-> frame_buffer_mb == 10'h000)
      else $error("undefined buffer code reserved memory");

   chk_vga_needs_fb: assert property (@(posedge clk) disable iff (!arst_n)
      vga_cycles_claim |-> !vga_dis_q && fb_size_q != GMC_FB_NONE)
      else $error("VGA claimed without buffer or while disabled");

   chk_subclass_legal: assert property (@(posedge clk) disable iff (!arst_n)
      gfx_subclass == GMC_SUBCLASS_VGA || gfx_subclass == GMC_SUBCLASS_OTHER)
      else $error("subclass code out of range");

   chk_rdata_fields: assert property (@(posedge clk) disable iff (!arst_n)
      cfg_rdata[GMC_XLAT_HI:GMC_XLAT_LO] == xlat_size_q && cfg_rdata[GMC_FB_HI:GMC_FB_LO]
      == fb_size_q && cfg_rdata[GMC_VGA_DIS_BIT] == vga_dis_q)
      else $error("read word does not show stored fields");

   cov_locked_write: cover property (@(posedge clk) disable iff (!arst_n)
      hit && smm_space_lock);
   cov_vga_off: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(vga_dis_q));
   cov_xlat_on: cover property (@(posedge clk) disable iff (!arst_n)
      $rose(xlat_cycles_claim));
   cov_fb_none: cover property (@(posedge clk) disable iff (!arst_n)
      fb_size_q == GMC_FB_NONE && vga_dis_q);
   cov_lane_high_only: cover property (@(posedge clk) disable iff (!arst_n)
      hit && cfg_be == 2'h2);
endmodule : gmc_regs
`default_nettype wire
